// >>> dv/sxb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sxb_asserts (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sxb_pkg::DM_W-1:0] dqm,
	input wire logic c_oe_n,
	input wire logic d_oe_n
);
	import sxb_pkg::*;
	wire logic rd;
	wire logic wr;
	assign rd = !cs_n && ras_n && !cas_n && we_n;
	assign wr = !cs_n && ras_n && !cas_n && !we_n;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	rd_latency_a: assert property (rd ##1 !wr [*2] |-> !d_oe_n)
		else $error("read data not on wire after latency");
	rd_burst_a: assert property (
		rd ##1 cs_n [*5] |-> !d_oe_n ##1 d_oe_n)
		else $error("read burst length wrong");
	rd_b2b_a: assert property (
		rd ##1 rd ##1 cs_n [*4] |-> !$past(d_oe_n, 3) && !d_oe_n
		##1 !d_oe_n ##1 d_oe_n)
		else $error("back to back read data not continuous");
	no_clash_a: assert property (!c_oe_n && !wr |-> d_oe_n)
		else $error("both ends drive data wire");
	wr_drive_a: assert property (wr |-> !c_oe_n)
		else $error("write without first data beat");
	wr_burst_a: assert property (
		wr ##1 cs_n [*4] |-> c_oe_n && !$past(c_oe_n))
		else $error("write burst length wrong");
	rd_flush_a: assert property (wr |=> d_oe_n [*2])
		else $error("read data after write registration");
	mask_guard_a: assert property (
		wr && !$past(d_oe_n) |-> $past(dqm) == 2'h3)
		else $error("mask not raised before write");
endmodule : sxb_asserts
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sxb_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	sxb_cmd_t req_cmd = CMD_NOP;
	logic [BA_W-1:0] req_bank = 2'h0;
	logic req_ap = 1'b0;
	logic [DQ_W-1:0] wdata = 16'h0000;
	logic [DM_W-1:0] wmask = 2'h0;
	logic [DQ_W-1:0] rd_src = 16'hbeef;
	logic req_ack, wdata_take, rd_valid, wr_valid, cmd_err;
	logic [DQ_W-1:0] rd_data;
	logic [DQ_W-1:0] wr_data;
	logic [BA_W-1:0] wr_bank;
	logic [DM_W-1:0] wr_mask;
	logic [DQ_W-1:0] rd_last = 16'h0000;
	logic [DM_W-1:0] mask_last = 2'h0;
	int n_take = 0;
	int n_cerr = 0;
	logic [NBANK-1:0] ap_start;
	logic [NBANK-1:0] ap_seen = '0;
	logic [NBANK-1:0] rec_seen = '0;
	sxb_bank_t bank_state [NBANK];
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_ack = 0;
	int n_rd = 0;
	int n_wr [NBANK] = '{default: 0};
	sxb_if bus ();
	sxb_ctrl u_sxb_ctrl (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .bus(bus),
		.i_cke(1'b1), .i_req_valid(req_valid), .i_req_cmd(req_cmd),
		.i_req_bank(req_bank), .i_req_ap(req_ap), .i_wdata(wdata),
		.i_wmask(wmask), .o_req_ack(req_ack), .o_wdata_take(wdata_take),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data));
	sxb_dev u_sxb_dev (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .bus(bus),
		.i_rd_data(rd_src), .o_bank_state(bank_state),
		.o_ap_start(ap_start), .o_wr_valid(wr_valid), .o_wr_bank(wr_bank),
		.o_wr_data(wr_data), .o_wr_mask(wr_mask), .o_cmd_err(cmd_err));
	sxb_asserts u_sxb_asserts (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
		.cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
		.we_n(bus.we_n), .dqm(bus.dqm), .c_oe_n(bus.c_oe_n),
		.d_oe_n(bus.d_oe_n));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// beat and event tallies, plus the run ceiling
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		wdata <= wdata + 16'h0101;
		if (req_ack === 1'b1) n_ack++;
		if (rd_valid === 1'b1) n_rd++;
		if (rd_valid === 1'b1) rd_last <= rd_data;
		if (wr_valid === 1'b1) n_wr[wr_bank]++;
		if (wr_valid === 1'b1) mask_last <= wr_mask;
		if (wdata_take === 1'b1) n_take++;
		if (cmd_err !== 1'b0) n_cerr++;
		ap_seen <= ap_seen | ap_start;
		for (int b = 0; b < NBANK; b++) begin
			if (bank_state[b] === BK_WR_RECOV) rec_seen[b] <= 1'b1;
		end
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %0h want %0h", $time, seen, exp);
		end
	endtask : chk
	task wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_n
	// one-cycle request, tried up to 8 times while refused
	task req(input sxb_cmd_t c, input logic [1:0] b, input logic ap,
		output logic ok);
		int i;
		ok = 1'b0;
		for (i = 0; i < 8 && !ok; i++) begin
			@(posedge sys_clk);
			req_valid <= 1'b1;
			req_cmd <= c;
			req_bank <= b;
			req_ap <= ap;
			@(posedge sys_clk);
			req_valid <= 1'b0;
			@(posedge sys_clk);
			ok = (req_ack === 1'b1);
		end
	endtask : req
	// two requests on consecutive edges, both must be taken
	task req2(input sxb_cmd_t c1, input logic [1:0] b1, input logic ap1,
		input sxb_cmd_t c2, input logic [1:0] b2, input logic ap2);
		int a;
		a = n_ack;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_cmd <= c1;
		req_bank <= b1;
		req_ap <= ap1;
		@(posedge sys_clk);
		req_cmd <= c2;
		req_bank <= b2;
		req_ap <= ap2;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		wait_n(3);
		chk(n_ack - a, 2);
	endtask : req2
	initial begin
		logic ok;
		int r0;
		int w0;
		int w1;
		int t0;
		wait_n(3);
		rst_n <= 1'b1;
		wait_n(1);
		chk(bus.cs_n, 1'b1);
		for (int b = 0; b < NBANK; b++) chk(bank_state[b], BK_IDLE);
		req(CMD_ACT, 2'h0, 1'b0, ok);
		chk(ok, 1'b1);
		req(CMD_ACT, 2'h1, 1'b0, ok);
		chk(ok, 1'b1);
		wait_n(6);
		chk(bank_state[0], BK_ACTIVE);
		chk(bank_state[1], BK_ACTIVE);
		req(CMD_RD, 2'h3, 1'b0, ok);
		chk(ok, 1'b0);
		r0 = n_rd;
		req(CMD_RD, 2'h0, 1'b0, ok);
		wait_n(12);
		chk(n_rd - r0, 4);
		chk(rd_last, 16'hbeef);
		r0 = n_rd;
		req2(CMD_RD, 2'h0, 1'b0, CMD_RD, 2'h1, 1'b0);
		wait_n(12);
		chk(n_rd - r0, 5);
		wmask <= 2'h2;
		w0 = n_wr[0];
		w1 = n_wr[1];
		t0 = n_take;
		req2(CMD_WR, 2'h0, 1'b0, CMD_WR, 2'h1, 1'b0);
		wait_n(10);
		chk(n_wr[0] - w0, 1);
		chk(n_wr[1] - w1, 4);
		chk(mask_last, 2'h2);
		chk(n_take - t0, 5);
		w0 = n_wr[0];
		r0 = n_rd;
		req2(CMD_WR, 2'h0, 1'b0, CMD_RD, 2'h1, 1'b0);
		wait_n(12);
		chk(n_wr[0] - w0, 1);
		chk(n_rd - r0, 4);
		w0 = n_wr[0];
		req(CMD_RD, 2'h1, 1'b0, ok);
		req(CMD_WR, 2'h0, 1'b0, ok);
		chk(ok, 1'b1);
		wait_n(10);
		chk(n_wr[0] - w0, 4);
		req(CMD_ACT, 2'h2, 1'b0, ok);
		wait_n(6);
		r0 = n_rd;
		req2(CMD_RD, 2'h1, 1'b0, CMD_PRE, 2'h2, 1'b0);
		wait_n(12);
		chk(n_rd - r0, 4);
		chk(bank_state[2], BK_IDLE);
		r0 = n_rd;
		req2(CMD_RD, 2'h0, 1'b1, CMD_RD, 2'h1, 1'b0);
		wait_n(3);
		chk(ap_seen[0], 1'b1);
		wait_n(12);
		chk(n_rd - r0, 5);
		chk(bank_state[0], BK_IDLE);
		req(CMD_ACT, 2'h0, 1'b0, ok);
		chk(ok, 1'b1);
		wait_n(6);
		req2(CMD_WR, 2'h0, 1'b1, CMD_RD, 2'h1, 1'b0);
		wait_n(12);
		chk(rec_seen[0], 1'b1);
		chk(bank_state[0], BK_IDLE);
		chk(n_cerr, 0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// >>> src/sxb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sxb_ctrl #(
	parameter int CL = sxb_pkg::CAS_LATENCY,
	parameter int BL = sxb_pkg::BURST_LEN
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	sxb_if.ctrl bus,
	input wire logic i_cke,
	input wire logic i_req_valid,
	input wire sxb_pkg::sxb_cmd_t i_req_cmd,
	input wire logic [sxb_pkg::BA_W-1:0] i_req_bank,
	input wire logic i_req_ap,
	input wire logic [sxb_pkg::DQ_W-1:0] i_wdata,
	input wire logic [sxb_pkg::DM_W-1:0] i_wmask,
	output logic o_req_ack,
	output logic o_wdata_take,
	output logic o_rd_valid,
	output logic [sxb_pkg::DQ_W-1:0] o_rd_data
);
	import sxb_pkg::*;
	logic open_row [NBANK];
	logic [TMR_W-1:0] tmr [NBANK];
	logic [TMR_W-1:0] wr_left;
	logic [TMR_W-1:0] rd_run;
	logic [CL-1:0] rd_sr;
	logic rd_ap_last;
	logic pin_wr;
	logic [1:0] guard;
	logic all_quiet;
	logic all_free;
	logic rd_bus;
	logic need_guard;
	logic permit;
	logic take;
	logic [2:0] enc;

	assign rd_bus = (|rd_sr) || (rd_run != '0);
	assign need_guard = (i_req_cmd == CMD_WR) && rd_bus &&
		(guard < (rd_ap_last ? 2'h2 : 2'h1)); // [RULE17] [RULE21]

	always_comb begin
		all_quiet = 1'b1;
		all_free = 1'b1;
		for (int b = 0; b < NBANK; b++) begin
			if (open_row[b] || tmr[b] != '0) all_quiet = 1'b0;
			if (tmr[b] != '0) all_free = 1'b0;
		end
		enc = ENC_NOP;
		permit = 1'b1;
		case (i_req_cmd)
			CMD_ACT: begin
				enc = ENC_ACT;
				permit = !open_row[i_req_bank] && tmr[i_req_bank] == '0;
			end
			CMD_RD: begin
				enc = ENC_RD;
				permit = open_row[i_req_bank] && tmr[i_req_bank] == '0;
			end
			CMD_WR: begin
				enc = ENC_WR;
				permit = open_row[i_req_bank] && tmr[i_req_bank] == '0 &&
					!need_guard;
			end
			CMD_PRE: begin
				enc = ENC_PRE;
				permit = i_req_ap ? all_free : tmr[i_req_bank] == '0;
			end
			CMD_STOP: enc = ENC_STOP;
			CMD_REF: begin
				enc = ENC_REF;
				permit = all_quiet && !rd_bus && wr_left == '0; // [RULE10]
			end
			CMD_MRS: begin
				enc = ENC_MRS;
				permit = all_quiet && !rd_bus && wr_left == '0; // [RULE10]
			end
			default: enc = ENC_NOP;
		endcase
	end
	// only encodable, tracked-legal commands leave the controller
	assign take = i_req_valid && permit; // [RULE12]

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.cke <= 1'b1;
			bus.cs_n <= 1'b1;
			bus.ras_n <= 1'b1;
			bus.cas_n <= 1'b1;
			bus.we_n <= 1'b1;
			bus.ba <= '0;
			bus.a10 <= 1'b0;
			o_req_ack <= 1'b0;
		end else begin
			bus.cke <= i_cke; // [RULE1]
			bus.cs_n <= !take;
			{bus.ras_n, bus.cas_n, bus.we_n} <= take ? enc : ENC_NOP; // [RULE4]
			if (take) begin
				bus.ba <= i_req_bank; // [RULE23]
				bus.a10 <= i_req_ap;
			end
			o_req_ack <= take;
		end
	end

	// write data and byte mask
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.c_dq <= '0;
			bus.c_oe_n <= 1'b1;
			bus.dqm <= '0;
			wr_left <= '0;
			guard <= '0;
			o_wdata_take <= 1'b0;
			pin_wr <= 1'b0;
		end else begin
			pin_wr <= take && i_req_cmd == CMD_WR;
			o_wdata_take <= 1'b0;
			if (take && i_req_cmd == CMD_WR) begin
				bus.c_dq <= i_wdata;
				bus.c_oe_n <= 1'b0;
				bus.dqm <= i_wmask;
				wr_left <= TMR_W'(BL - 1);
				guard <= '0;
				o_wdata_take <= 1'b1;
			end else if (take && i_req_cmd == CMD_RD) begin
				bus.c_oe_n <= 1'b1;
				bus.dqm <= '0;
				wr_left <= '0;
				guard <= '0;
			end else if (wr_left != '0) begin
				bus.c_dq <= i_wdata;
				bus.dqm <= i_wmask;
				wr_left <= wr_left - 1'b1;
				o_wdata_take <= 1'b1;
			end else if (i_req_valid && need_guard) begin
				// mask the read data ahead of a write
				bus.c_oe_n <= 1'b1;
				bus.dqm <= '1; // [RULE17] [RULE21]
				guard <= guard + 1'b1;
			end else begin
				// keep the mask up once raised, until a write or a read is taken
				bus.c_oe_n <= 1'b1;
				bus.dqm <= {DM_W{guard != '0}}; // [RULE17] [RULE21]
			end
		end
	end

	// read data return, cut short by a write on the pins
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_run <= '0;
			rd_sr <= '0;
			rd_ap_last <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			if (take && i_req_cmd == CMD_RD) begin
				rd_run <= TMR_W'(BL);
				rd_ap_last <= i_req_ap;
			end else if ((take && i_req_cmd inside {CMD_WR, CMD_STOP}) ||
				pin_wr) begin
				rd_run <= '0;
			end else if (rd_run != '0) begin
				rd_run <= rd_run - 1'b1;
			end
			if (pin_wr)
				rd_sr <= '0; // [RULE17]
			else
				rd_sr <= {rd_sr[CL-2:0], rd_run != '0}; // [RULE16]
			o_rd_valid <= rd_sr[CL-1] && !pin_wr;
			o_rd_data <= bus.dq;
		end
	end

	// per-bank open row and busy tracking
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int b = 0; b < NBANK; b++) begin
				open_row[b] <= 1'b0;
				tmr[b] <= '0;
			end
		end else begin
			for (int b = 0; b < NBANK; b++) begin
				if (tmr[b] != '0) tmr[b] <= tmr[b] - 1'b1;
				if (take && i_req_bank == BA_W'(b)) begin
					if (i_req_cmd == CMD_ACT) begin
						open_row[b] <= 1'b1;
						tmr[b] <= TMR_W'(ACTIVATE_TO_ACCESS_DELAY_CYC);
					end else if (i_req_cmd inside {CMD_RD, CMD_WR} && i_req_ap) begin
						open_row[b] <= 1'b0;
						tmr[b] <= TMR_W'(BL + WRITE_RECOVERY_TIME_CYC +
							PRECHARGE_PERIOD_CYC);
					end
				end
				if (take && (i_req_cmd == CMD_PRE &&
					(i_req_ap || i_req_bank == BA_W'(b)))) begin
					open_row[b] <= 1'b0;
					tmr[b] <= TMR_W'(PRECHARGE_PERIOD_CYC);
				end
				if (take && i_req_cmd inside {CMD_REF, CMD_MRS})
					tmr[b] <= TMR_W'(PRECHARGE_PERIOD_CYC);
			end
		end
	end
endmodule : sxb_ctrl
`default_nettype wire

// >>> src/sxb_dev.sv
// Summary of operation
// RULE1 - commands count only with clock gate high twice
// RULE2 - chip select high inhibits; operations continue
// RULE3 - all strobes high is no-operation
// RULE4 - strobe patterns encode activate, read, write, precharge
// RULE5 - each bank takes commands by its own state
// RULE6 - idle bank never limits the other banks
// RULE7 - idle after precharge period; active after access delay
// RULE8 - plain burst marks bank reading or writing
// RULE9 - auto precharge burst busy until precharge ends
// RULE10 - refresh and mode load need all banks idle
// RULE11 - burst stop hits only the running burst
// RULE12 - controller sends only listed legal sequences
// RULE13 - reads and writes allowed with or without precharge
// RULE14 - interrupted auto precharge burst starts own precharge
// RULE15 - activate or precharge elsewhere leaves burst running
// RULE16 - read after read cuts over latency later
// RULE17 - write cuts read at once; mask beforehand
// RULE18 - read cuts write; last beat one clock before
// RULE19 - write cuts write; last beat one clock before
// RULE20 - read cuts auto precharge read; precharge at registration
// RULE21 - write cuts auto precharge read; mask two clocks early
// RULE22 - read cuts auto precharge write; precharge after recovery
// RULE23 - bank select sampled with the command strobes
`timescale 1ns/1ps
`default_nettype none
module sxb_dev #(
	parameter int CL = sxb_pkg::CAS_LATENCY,
	parameter int BL = sxb_pkg::BURST_LEN
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	sxb_if.dev bus,
	input wire logic [sxb_pkg::DQ_W-1:0] i_rd_data,
	output var sxb_pkg::sxb_bank_t o_bank_state [sxb_pkg::NBANK],
	output logic [sxb_pkg::NBANK-1:0] o_ap_start,
	output logic o_wr_valid,
	output logic [sxb_pkg::BA_W-1:0] o_wr_bank,
	output logic [sxb_pkg::DQ_W-1:0] o_wr_data,
	output logic [sxb_pkg::DM_W-1:0] o_wr_mask,
	output logic o_cmd_err
);
	import sxb_pkg::*;
	logic cke_q;
	logic [TMR_W-1:0] xsr_cnt;
	logic go;
	sxb_cmd_t cmd;
	logic [BA_W-1:0] tgt;
	logic err;
	logic ok;
	logic is_rw;
	logic pre_cut;
	logic stop;
	logic end_evt;
	logic cur_active;
	logic cur_wr;
	logic [BA_W-1:0] cur_bank;
	logic [TMR_W-1:0] cur_left;
	logic wr_beat;
	logic rd_beat;
	logic all_idle;
	logic any_busy;
	logic [TMR_W-1:0] tmr [NBANK];
	logic [TMR_W-1:0] next_tmr [NBANK];
	sxb_bank_t next_st [NBANK];
	logic [NBANK-1:0] next_ap;
	logic [DQ_W-1:0] rd_d [CL];
	logic [CL-1:0] rd_oe_n;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cke_q <= 1'b1;
			xsr_cnt <= '0;
		end else begin
			cke_q <= bus.cke;
			// clock gate rising again: hold off for the exit time
			if (!cke_q && bus.cke)
				xsr_cnt <= TMR_W'(SELF_REFRESH_EXIT_TIME_CYC); // [RULE1]
			else if (xsr_cnt != '0)
				xsr_cnt <= xsr_cnt - 1'b1;
		end
	end

	assign go = cke_q && bus.cke && xsr_cnt == '0 && !bus.cs_n; // [RULE1] [RULE2]
	assign tgt = bus.ba; // [RULE23]

	always_comb begin
		cmd = CMD_NOP;
		if (go) begin
			case ({bus.ras_n, bus.cas_n, bus.we_n}) // [RULE3] [RULE4]
				ENC_ACT: cmd = CMD_ACT;
				ENC_RD: cmd = CMD_RD;
				ENC_WR: cmd = CMD_WR;
				ENC_PRE: cmd = CMD_PRE;
				ENC_STOP: cmd = CMD_STOP;
				ENC_REF: cmd = CMD_REF;
				ENC_MRS: cmd = CMD_MRS;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	always_comb begin
		all_idle = 1'b1;
		any_busy = cur_active;
		for (int b = 0; b < NBANK; b++) begin
			if (o_bank_state[b] != BK_IDLE) all_idle = 1'b0;
			if (o_bank_state[b] inside {BK_ACTIVATING, BK_READ_AP,
				BK_WRITE_AP, BK_WR_RECOV}) any_busy = 1'b1;
		end
		// legality judged on the target bank, or on all banks for refresh, mode load and precharge all
		case (cmd) // [RULE5] [RULE6]
			CMD_ACT: err = o_bank_state[tgt] != BK_IDLE;
			CMD_RD, CMD_WR: err = !(o_bank_state[tgt] inside
				{BK_ACTIVE, BK_READ, BK_WRITE}); // [RULE13]
			CMD_PRE: err = bus.a10 ? any_busy : o_bank_state[tgt] inside
				{BK_ACTIVATING, BK_READ_AP, BK_WRITE_AP, BK_WR_RECOV};
			CMD_REF, CMD_MRS: err = !all_idle; // [RULE10]
			default: err = 1'b0;
		endcase
	end

	assign ok = go && !err;
	assign is_rw = ok && (cmd == CMD_RD || cmd == CMD_WR);
	// precharge of the bursting bank itself truncates; elsewhere it does not
	assign pre_cut = ok && cmd == CMD_PRE && cur_active &&
		(bus.a10 || tgt == cur_bank); // [RULE15]
	assign stop = ok && cmd == CMD_STOP && cur_active; // [RULE11]
	assign end_evt = cur_active && cur_left == TMR_W'(1) && !is_rw &&
		!stop && !pre_cut;
	assign wr_beat = (is_rw && cmd == CMD_WR) ||
		(cur_active && cur_wr && !is_rw && !stop && !pre_cut); // [RULE18] [RULE19]
	assign rd_beat = (is_rw && cmd == CMD_RD) ||
		(cur_active && !cur_wr && !is_rw && !stop && !pre_cut);

	always_comb begin
		for (int b = 0; b < NBANK; b++) begin
			next_st[b] = o_bank_state[b];
			next_tmr[b] = (tmr[b] != '0) ? tmr[b] - 1'b1 : '0;
			next_ap[b] = 1'b0;
			if (ok && cmd == CMD_ACT && tgt == BA_W'(b)) begin
				next_st[b] = BK_ACTIVATING;
				next_tmr[b] = TMR_W'(ACTIVATE_TO_ACCESS_DELAY_CYC - 1);
			end else if (is_rw && tgt == BA_W'(b)) begin
				if (cmd == CMD_RD) // [RULE8] [RULE9]
					next_st[b] = bus.a10 ? BK_READ_AP : BK_READ;
				else
					next_st[b] = bus.a10 ? BK_WRITE_AP : BK_WRITE;
			end else if (ok && cmd == CMD_PRE && (bus.a10 || tgt == BA_W'(b))
				&& o_bank_state[b] != BK_IDLE) begin
				next_st[b] = BK_PRECHARGING;
				next_tmr[b] = TMR_W'(PRECHARGE_PERIOD_CYC - 1);
			end else if (cur_active && cur_bank == BA_W'(b) &&
				(is_rw || stop || end_evt)) begin
				case (o_bank_state[b])
					BK_READ, BK_WRITE: next_st[b] = BK_ACTIVE;
					BK_READ_AP: begin
						// precharge begins at the interrupting registration
						next_st[b] = BK_PRECHARGING; // [RULE14] [RULE20] [RULE21]
						next_tmr[b] = TMR_W'(PRECHARGE_PERIOD_CYC - 1);
						next_ap[b] = 1'b1;
					end
					BK_WRITE_AP: begin
						next_st[b] = BK_WR_RECOV; // [RULE14] [RULE22]
						next_tmr[b] = TMR_W'(WRITE_RECOVERY_TIME_CYC - 1);
					end
					default: next_st[b] = o_bank_state[b];
				endcase
			end else if (tmr[b] == '0) begin
				case (o_bank_state[b]) // [RULE7]
					BK_ACTIVATING: next_st[b] = BK_ACTIVE;
					BK_PRECHARGING: next_st[b] = BK_IDLE;
					BK_WR_RECOV: begin
						next_st[b] = BK_PRECHARGING; // [RULE22]
						next_tmr[b] = TMR_W'(PRECHARGE_PERIOD_CYC - 1);
						next_ap[b] = 1'b1;
					end
					default: next_st[b] = o_bank_state[b];
				endcase
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int b = 0; b < NBANK; b++) begin
				o_bank_state[b] <= BK_IDLE;
				tmr[b] <= '0;
			end
			o_ap_start <= '0;
			o_cmd_err <= 1'b0;
		end else begin
			for (int b = 0; b < NBANK; b++) begin
				o_bank_state[b] <= next_st[b];
				tmr[b] <= next_tmr[b];
			end
			o_ap_start <= next_ap;
			o_cmd_err <= go && err;
		end
	end

	// the one running burst, whichever bank owns it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur_active <= 1'b0;
			cur_wr <= 1'b0;
			cur_bank <= '0;
			cur_left <= '0;
		end else if (is_rw) begin
			cur_active <= BL > 1;
			cur_wr <= cmd == CMD_WR;
			cur_bank <= tgt;
			cur_left <= TMR_W'(BL - 1);
		end else if (stop || end_evt || pre_cut) begin
			cur_active <= 1'b0; // [RULE11]
		end else if (cur_active) begin
			cur_left <= cur_left - 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wr_valid <= 1'b0;
			o_wr_bank <= '0;
			o_wr_data <= '0;
			o_wr_mask <= '0;
		end else begin
			o_wr_valid <= wr_beat; // [RULE19]
			o_wr_bank <= is_rw ? tgt : cur_bank;
			o_wr_data <= bus.dq;
			o_wr_mask <= bus.dqm;
		end
	end

	// read data pipe; a write registration empties it at once
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_oe_n <= '1;
			for (int i = 0; i < CL; i++) rd_d[i] <= '0;
		end else if (is_rw && cmd == CMD_WR) begin
			rd_oe_n <= '1; // [RULE17]
		end else begin
			rd_oe_n <= {rd_oe_n[CL-2:0], !rd_beat}; // [RULE16] [RULE18]
			rd_d[0] <= i_rd_data;
			for (int i = 1; i < CL; i++) rd_d[i] <= rd_d[i-1];
		end
	end

	assign bus.d_dq = rd_d[CL-1];
	assign bus.d_oe_n = rd_oe_n[CL-1];
endmodule : sxb_dev
`default_nettype wire

// >>> src/sxb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sxb_if;
	import sxb_pkg::*;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BA_W-1:0] ba;
	logic a10;
	logic [DM_W-1:0] dqm;
	logic [DQ_W-1:0] c_dq;
	logic c_oe_n;
	logic [DQ_W-1:0] d_dq;
	logic d_oe_n;
	logic [DQ_W-1:0] dq;
	// shared data wire level from the two enables
	assign dq = !c_oe_n ? c_dq : (!d_oe_n ? d_dq : '0);
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, a10, dqm, c_dq,
		c_oe_n, input dq);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, a10, dqm, dq,
		output d_dq, d_oe_n);
endinterface : sxb_if
`default_nettype wire

// >>> src/sxb_pkg.sv
package sxb_pkg;
	localparam int NBANK = 4;
	localparam int BA_W = 2;
	localparam int DQ_W = 16;
	localparam int DM_W = 2;
	localparam int CAS_LATENCY = 2;
	localparam int BURST_LEN = 4;
	localparam int TMR_W = 8;
	localparam int CLK_PERIOD_PS = 8000;
	// bank timing figures, in nanoseconds
	localparam int PRECHARGE_PERIOD_NS = 20;
	localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
	// least times, rounded up to whole clocks
	localparam int PRECHARGE_PERIOD_CYC =
		(PRECHARGE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACTIVATE_TO_ACCESS_DELAY_CYC =
		(ACTIVATE_TO_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WRITE_RECOVERY_TIME_CYC =
		(WRITE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_TIME_CYC =
		(SELF_REFRESH_EXIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// strobe codes {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] ENC_NOP = 3'h7;
	localparam logic [2:0] ENC_ACT = 3'h3;
	localparam logic [2:0] ENC_RD = 3'h5;
	localparam logic [2:0] ENC_WR = 3'h4;
	localparam logic [2:0] ENC_PRE = 3'h2;
	localparam logic [2:0] ENC_STOP = 3'h6;
	localparam logic [2:0] ENC_REF = 3'h1;
	localparam logic [2:0] ENC_MRS = 3'h0;
	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_STOP, CMD_REF, CMD_MRS
	} sxb_cmd_t;
	typedef enum logic [3:0] {
		BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
		BK_READ_AP, BK_WRITE_AP, BK_WR_RECOV, BK_PRECHARGING
	} sxb_bank_t;
endpackage : sxb_pkg
